// [core/rdcs_pkg.sv]
`default_nettype none
package rdcs_pkg;

  // ==========================================================================
  // Register map (byte addresses)
  localparam logic [3:0]  RDCS_CFG_OFF    = 4'h0;
  localparam logic [3:0]  RDCS_CTRL_OFF   = 4'h4;
  localparam logic [3:0]  RDCS_STAT_OFF   = 4'h8;
  localparam logic [3:0]  RDCS_CAUSE_OFF  = 4'hC;

  // ==========================================================================
  // Field positions
  localparam int          CFG_SWITCH_BIT  = 0;
  localparam int          CFG_POWER_UP_TIMER_BIT    = 1;
  localparam int          CFG_TWOSPD_BIT  = 2;
  localparam int          CFG_INIT_LSB    = 4;
  localparam int          CTRL_CUR_LSB    = 0;
  localparam int          STAT_REL_BIT    = 0;
  localparam int          STAT_CLKOK_BIT  = 1;
  localparam int          STAT_RUN_BIT    = 2;
  localparam int          STAT_CFM_BIT    = 3;
  localparam int          STAT_CUR_LSB    = 4;
  localparam int          CAUSE_POR_BIT   = 0;
  localparam int          CAUSE_BOR_BIT   = 1;
  localparam int          CAUSE_EXT_BIT   = 2;
  localparam int          CAUSE_WDT_BIT   = 3;
  localparam int          CAUSE_SWR_BIT   = 4;

  // ==========================================================================
  // Values after reset, and AXI response codes
  localparam logic [7:0]  CFG_RESET       = 8'h02;
  localparam logic [2:0]  CUR_RESET       = 3'h0;
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;

  // ==========================================================================
  // Timing
  localparam int          CLK_PERIOD_NS      = 10;
  localparam int          POWER_UP_DELAY_MS  = 64;
  localparam int          POWER_ON_DELAY_US  = 10;
  localparam int          CFM_DELAY_US       = 2;
  localparam int          POWER_UP_DELAY_CYC =
    (POWER_UP_DELAY_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          POWER_ON_DELAY_CYC =
    (POWER_ON_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          CFM_DELAY_CYC      =
    (CFM_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [9:0]  OST_LAST        = 10'h3FF;

  // ==========================================================================
  // Types
  typedef enum logic [2:0] {
    OSC_FRC, OSC_FRCPLL, OSC_EC, OSC_ECPLL,
    OSC_XT, OSC_XTPLL, OSC_SOSC, OSC_LOW_POWER_RC_OSCILLATOR
  } rdcs_osc_e;

  typedef enum logic [1:0] {ST_HOLD, ST_DELAY, ST_RUN} rdcs_state_e;

endpackage
`default_nettype wire

// [core/rdcs_top.sv]
`timescale 1ns/100ps
`default_nettype none
module rdcs_top
  import rdcs_pkg::*;
#(
  parameter int unsigned POWER_UP_TIMER_CYC = POWER_UP_DELAY_CYC,
  parameter int unsigned POR_CYC  = POWER_ON_DELAY_CYC,
  parameter int unsigned CFM_CYC  = CFM_DELAY_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        power_on_reset,
  input  wire logic        brownout_reset,
  input  wire logic        external_clear_pin_n,
  input  wire logic        watchdog_timeout_reset,
  input  wire logic        software_reset_instr,
  input  wire logic        osc_period_tick,
  input  wire logic        frc_ready,
  input  wire logic        low_power_rc_oscillator_ready,
  input  wire logic        pll_lock,
  output logic             system_reset_release,
  output logic             sys_clk_gate,
  output logic             cpu_run,
  output logic             clock_fail_monitor_en,
  output logic [2:0]       active_osc_select
);

  localparam int DLY_W = 24;

  // Waits for a source: {frc, low_power_rc_oscillator, ost, pll}
  function automatic logic [3:0] rdcs_needs(input logic [2:0] sel,
                                            input logic       two_spd);
    rdcs_osc_e s;
    s = rdcs_osc_e'(sel);
    if (two_spd) begin
      rdcs_needs = 4'h8;
    end else begin
      rdcs_needs = {s == OSC_FRC || s == OSC_FRCPLL,
                    s == OSC_LOW_POWER_RC_OSCILLATOR,
                    s == OSC_XT || s == OSC_XTPLL || s == OSC_SOSC,
                    s == OSC_FRCPLL || s == OSC_ECPLL || s == OSC_XTPLL};
    end
  endfunction

  // ==========================================================================
  // Registers and state
  logic [7:0]       cfg;
  logic [2:0]       cur_osc;
  logic [4:0]       cause;
  rdcs_state_e      state;
  logic [DLY_W-1:0] delay_cnt;
  logic             hold_por;
  logic             hold_bor;
  logic [2:0]       wait_sel;
  logic             ts_lat;
  logic [9:0]       ost_cnt;
  logic             ost_done;
  logic             pll_done;
  logic [DLY_W-1:0] cfm_cnt;
  logic             aw_full;
  logic [3:0]       aw_addr;
  logic             w_full;
  logic [7:0]       w_byte;
  logic             w_lane0;

  // ==========================================================================
  // Decode
  wire [4:0] src_now    = {software_reset_instr, watchdog_timeout_reset,
                           !external_clear_pin_n, brownout_reset,
                           power_on_reset};
  wire       any_src    = |src_now;
  wire       hold_exit  = (state == ST_HOLD) && !any_src;
  wire       switch_en  = cfg[CFG_SWITCH_BIT];
  wire       power_up_timer_en    = cfg[CFG_POWER_UP_TIMER_BIT];
  wire [2:0] init_sel   = cfg[CFG_INIT_LSB +: 3];
  wire       cold       = hold_por || hold_bor;
  wire [2:0] chosen     = (!switch_en || cold) ? init_sel : cur_osc;
  wire [DLY_W-1:0] power_up_timer_d = power_up_timer_en ? DLY_W'(POWER_UP_TIMER_CYC) : '0;
  wire [DLY_W-1:0] load_d = hold_por ? DLY_W'(POR_CYC) + power_up_timer_d :
                            hold_bor ? power_up_timer_d : '0;
  wire [3:0] needs      = rdcs_needs(wait_sel, ts_lat);
  wire       osc_ok     = (!needs[3] || frc_ready) &&
                          (!needs[2] || low_power_rc_oscillator_ready) &&
                          (!needs[1] || ost_done);
  wire       pll_ok     = !needs[0] || pll_done;
  wire       clk_ok     = (state != ST_HOLD) && osc_ok && pll_ok;
  wire       do_write   = aw_full && w_full && !s_axi_bvalid;
  wire       wr_ok      = aw_addr != RDCS_STAT_OFF;
  wire       ar_take    = s_axi_arvalid && s_axi_arready;
  wire       rd_ok      = 1'b1;
  wire [31:0] stat_word = {25'h0, cur_osc, clock_fail_monitor_en, cpu_run,
                           clk_ok, system_reset_release};
  wire [31:0] rd_mux    =
    (s_axi_araddr == RDCS_CFG_OFF)   ? {24'h0, cfg}    :
    (s_axi_araddr == RDCS_CTRL_OFF)  ? {29'h0, cur_osc} :
    (s_axi_araddr == RDCS_STAT_OFF)  ? stat_word       :
    (s_axi_araddr == RDCS_CAUSE_OFF) ? {27'h0, cause}  : 32'h0;
  wire       rd_map     = (s_axi_araddr[1:0] == 2'h0) && rd_ok;
  wire       wr_map     = aw_addr[1:0] == 2'h0;
  wire       wr_en      = do_write && w_lane0 && wr_map && wr_ok;
  wire [4:0] cause_clr  = (wr_en && aw_addr == RDCS_CAUSE_OFF) ?
                          w_byte[4:0] : 5'h0;

  assign s_axi_awready = !aw_full && !s_axi_bvalid;
  assign s_axi_wready  = !w_full && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // ==========================================================================
  // AXI4-Lite slave
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_full <= 1'b0;
      w_full  <= 1'b0;
      aw_addr <= 4'h0;
      w_byte  <= 8'h00;
      w_lane0 <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_full <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full  <= 1'b1;
        w_byte  <= s_axi_wdata[7:0];
        w_lane0 <= s_axi_wstrb[0];
      end else if (do_write) begin
        w_full <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= RESP_OKAY;
      s_axi_rdata  <= 32'h0;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_map && wr_ok) ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_map ? rd_mux : 32'h0;
        s_axi_rresp  <= rd_map ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ==========================================================================
  // Software registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cfg     <= CFG_RESET;
      cur_osc <= CUR_RESET;
      cause   <= 5'h01;
    end else begin
      if (wr_en && aw_addr == RDCS_CFG_OFF) begin
        cfg <= w_byte;
      end
      if (hold_exit) begin
        cur_osc <= chosen;
      end else if (wr_en && aw_addr == RDCS_CTRL_OFF && switch_en) begin
        cur_osc <= w_byte[CTRL_CUR_LSB +: 3];
      end
      cause <= (cause & ~cause_clr) | src_now;
    end
  end

  // ==========================================================================
  // Reset sequencer
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state                <= ST_HOLD;
      hold_por             <= 1'b1;
      hold_bor             <= 1'b0;
      delay_cnt            <= '0;
      wait_sel             <= CUR_RESET;
      ts_lat               <= 1'b0;
      system_reset_release <= 1'b0;
    end else if (any_src) begin
      state                <= ST_HOLD;
      hold_por             <= (state == ST_HOLD && hold_por) || power_on_reset;
      hold_bor             <= (state == ST_HOLD && hold_bor) || brownout_reset;
      system_reset_release <= 1'b0;
    end else begin
      unique case (state)
        ST_HOLD: begin
          state     <= ST_DELAY;
          delay_cnt <= load_d;
          wait_sel  <= chosen;
          ts_lat    <= cfg[CFG_TWOSPD_BIT];
        end
        ST_DELAY: begin
          if (delay_cnt == '0) begin
            state                <= ST_RUN;
            system_reset_release <= 1'b1;
          end else begin
            delay_cnt <= delay_cnt - 1'b1;
          end
        end
        ST_RUN: begin
          hold_por <= 1'b0;
          hold_bor <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================================
  // Oscillator waits, in parallel with the delay
  // waits run alongside
  always_ff @(posedge sys_clk) begin
    if (rst || state == ST_HOLD) begin
      ost_cnt  <= 10'h0;
      ost_done <= 1'b0;
      pll_done <= 1'b0;
    end else begin
      if (needs[1] && osc_period_tick && !ost_done) begin
        ost_cnt  <= ost_cnt + 10'h1;
        ost_done <= ost_cnt == OST_LAST;
      end
      // lock sampled only once start-up is over
      if (osc_ok && pll_lock) begin
        pll_done <= 1'b1;
      end
    end
  end

  // ==========================================================================
  // Outputs
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sys_clk_gate          <= 1'b0;
      cpu_run               <= 1'b0;
      cfm_cnt               <= '0;
      clock_fail_monitor_en <= 1'b0;
    end else begin
      sys_clk_gate <= clk_ok && !any_src;
      cpu_run      <= clk_ok && system_reset_release && !any_src;
      if (!system_reset_release || any_src) begin
        cfm_cnt               <= '0;
        clock_fail_monitor_en <= 1'b0;
      end else if (cfm_cnt == DLY_W'(CFM_CYC)) begin
        clock_fail_monitor_en <= 1'b1;
      end else begin
        cfm_cnt <= cfm_cnt + 1'b1;
      end
    end
  end

  assign active_osc_select = cur_osc;

  // ==========================================================================
  // Assertions
  property p_hold_blocks;
    @(posedge sys_clk) disable iff (rst) any_src |=> !system_reset_release;
  endproperty
  a_hold_blocks: assert property (p_hold_blocks)
    else $error("reset released while a source was active");

  property p_rel_cause;
    @(posedge sys_clk) disable iff (rst) $rose(system_reset_release) |->
      $past(state) == ST_DELAY && $past(delay_cnt) == '0;
  endproperty
  a_rel_cause: assert property (p_rel_cause)
    else $error("release without expired delay");

  property p_warm_zero;
    @(posedge sys_clk) disable iff (rst)
      hold_exit && !hold_por && !hold_bor ##1 !any_src [*2]
      |-> system_reset_release;
  endproperty
  a_warm_zero: assert property (p_warm_zero)
    else $error("warm reset not released in two cycles");

  property p_bor_power_up_timer;
    @(posedge sys_clk) disable iff (rst)
      hold_exit && hold_bor && !hold_por |=> delay_cnt == $past(power_up_timer_d);
  endproperty
  a_bor_power_up_timer: assert property (p_bor_power_up_timer)
    else $error("brown-out delay differs from power-up delay");

  property p_sel_fixed;
    @(posedge sys_clk) disable iff (rst)
      hold_exit && !switch_en |=> cur_osc == $past(init_sel);
  endproperty
  a_sel_fixed: assert property (p_sel_fixed)
    else $error("source not from configuration");

  property p_sel_keep;
    @(posedge sys_clk) disable iff (rst)
      hold_exit && switch_en && !cold |=> cur_osc == $past(cur_osc);
  endproperty
  a_sel_keep: assert property (p_sel_keep)
    else $error("warm reset changed current source");

  property p_run_needs;
    @(posedge sys_clk) disable iff (rst)
      cpu_run |-> system_reset_release && $past(clk_ok);
  endproperty
  a_run_needs: assert property (p_run_needs)
    else $error("execution before waits complete");

  property p_gate;
    @(posedge sys_clk) disable iff (rst) sys_clk_gate |-> $past(clk_ok);
  endproperty
  a_gate: assert property (p_gate)
    else $error("clock passed before ready");

  property p_ost;
    @(posedge sys_clk) disable iff (rst) $rose(ost_done) |->
      $past(ost_cnt) == OST_LAST && $past(osc_period_tick);
  endproperty
  a_ost: assert property (p_ost)
    else $error("start-up timer ended early");

  property p_pll_after;
    @(posedge sys_clk) disable iff (rst) $rose(pll_done) |-> $past(osc_ok);
  endproperty
  a_pll_after: assert property (p_pll_after)
    else $error("lock taken before start-up");

  property p_cfm_late;
    @(posedge sys_clk) disable iff (rst)
      $rose(system_reset_release) |-> !clock_fail_monitor_en [*2];
  endproperty
  a_cfm_late: assert property (p_cfm_late)
    else $error("monitor started with release");

  property p_two_speed;
    @(posedge sys_clk) disable iff (rst)
      state == ST_DELAY && ts_lat && frc_ready |-> clk_ok;
  endproperty
  a_two_speed: assert property (p_two_speed)
    else $error("two-speed start waited beyond fast RC");

  c_cold_run: cover property (@(posedge sys_clk) disable iff (rst)
    hold_exit && hold_por ##[1:1000] cpu_run);
  c_warm_run: cover property (@(posedge sys_clk) disable iff (rst)
    hold_exit && !cold ##[1:300] cpu_run);
  c_parallel: cover property (@(posedge sys_clk) disable iff (rst)
    state == ST_DELAY && clk_ok);
  c_monitor: cover property (@(posedge sys_clk) disable iff (rst)
    $rose(clock_fail_monitor_en));

endmodule // rdcs_top
`default_nettype wire

// [testbench/rdcs_osc_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ==========================================================================
// Oscillator sources facing the sequencer
module rdcs_osc_model #(
  parameter int FRC_DLY  = 30,
  parameter int LOW_POWER_RC_OSCILLATOR_DLY = 50,
  parameter int LOCK_DLY = 3000
) (
  input  wire logic sys_clk,
  input  wire logic restart,
  output logic      osc_period_tick,
  output logic      frc_ready,
  output logic      low_power_rc_oscillator_ready,
  output logic      pll_lock
);
  int   cnt = 0;
  logic ph  = 1'b0;

  // Start-up and lock times begin again with every reset
  always_ff @(posedge sys_clk) begin
    ph <= ~ph;
    if (restart) cnt <= 0;
    else if (cnt < 65535) cnt <= cnt + 1;
  end

  // One tick every second cycle: oscillator period is two cycles
  assign osc_period_tick = ph;
  assign frc_ready       = !restart && (cnt >= FRC_DLY);
  assign low_power_rc_oscillator_ready      = !restart && (cnt >= LOW_POWER_RC_OSCILLATOR_DLY);
  assign pll_lock        = !restart && (cnt >= LOCK_DLY);
endmodule // rdcs_osc_model
`default_nettype wire

// [testbench/test_reset_delay_clock_select.sv]
`timescale 1ns/100ps
`default_nettype none
module test_reset_delay_clock_select
  import rdcs_pkg::*;
;
  localparam int POWER_UP_TIMER = 20;
  localparam int PORC = 10;
  localparam int CFM  = 5;
  localparam int FRCD = 30;
  localparam int LPRD = 50;
  localparam int LOCK = 3000;
  localparam int OSCILLATOR_STARTUP_TIMER  = 2048;

  logic        sys_clk = 1'b0;
  logic        rst;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [4:0]  src;
  logic        tick, frc_rdy, low_power_rc_oscillator_rdy, lock;
  logic        rel, gate, run, cfm_en;
  logic [2:0]  act;
  int          num_errors = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          lr, lg, lc, lm, l0;
  logic [31:0] d;
  logic [1:0]  r;
  int          dly [8] = '{FRCD, LOCK, 0, LOCK, OSCILLATOR_STARTUP_TIMER, LOCK, OSCILLATOR_STARTUP_TIMER, LPRD};

  always #5 sys_clk = ~sys_clk;

  rdcs_top #(.POWER_UP_TIMER_CYC(POWER_UP_TIMER), .POR_CYC(PORC), .CFM_CYC(CFM)) dut (
    .sys_clk(sys_clk), .rst(rst),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .power_on_reset(src[0]),
    .brownout_reset(src[1]), .external_clear_pin_n(~src[2]),
    .watchdog_timeout_reset(src[3]), .software_reset_instr(src[4]),
    .osc_period_tick(tick), .frc_ready(frc_rdy), .low_power_rc_oscillator_ready(low_power_rc_oscillator_rdy),
    .pll_lock(lock), .system_reset_release(rel), .sys_clk_gate(gate),
    .cpu_run(run), .clock_fail_monitor_en(cfm_en),
    .active_osc_select(act)
  );

  rdcs_osc_model #(.FRC_DLY(FRCD), .LOW_POWER_RC_OSCILLATOR_DLY(LPRD), .LOCK_DLY(LOCK)) osc (
    .sys_clk(sys_clk), .restart(rst || (|src)), .osc_period_tick(tick),
    .frc_ready(frc_rdy), .low_power_rc_oscillator_ready(low_power_rc_oscillator_rdy), .pll_lock(lock)
  );

  // ==========================================================================
  // Compare and closing
  task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_range(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask

  task automatic complete_run();
    $display("Mismatches %0d, comparisons %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 80000) begin
      num_errors++;
      complete_run();
    end
  end

  // ==========================================================================
  // AXI4-Lite master
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] v,
                        output logic [1:0] resp);
    logic aw_t, w_t, b_t;
    @(posedge sys_clk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge sys_clk);
      aw_t = awvalid && awready;
      w_t  = wvalid && wready;
      b_t  = bvalid;
      resp = bresp;
      @(posedge sys_clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
    end while (b_t !== 1'b1);
    bready <= 1'b0;
  endtask

  task automatic axi_rd(input logic [3:0] a, output logic [31:0] v,
                        output logic [1:0] resp);
    logic ar_t, r_t;
    @(posedge sys_clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(negedge sys_clk);
      ar_t = arvalid && arready;
      r_t  = rvalid;
      v    = rdata;
      resp = rresp;
      @(posedge sys_clk);
      if (ar_t) arvalid <= 1'b0;
    end while (r_t !== 1'b1);
    rready <= 1'b0;
  endtask

  // ==========================================================================
  // One reset source held for three cycles, then the release timed
  task automatic run_seq(input int s);
    int n, e;
    @(posedge sys_clk);
    src[s] <= 1'b1;
    repeat (3) @(posedge sys_clk);
    src[s] <= 1'b0;
    lr = -1;
    lg = -1;
    lc = -1;
    lm = -1;
    n  = 0;
    while (n < 6000 && (lc < 0 || lm < 0)) begin
      @(negedge sys_clk);
      n++;
      if (lr < 0 && rel === 1'b1) lr = n;
      if (lg < 0 && gate === 1'b1) lg = n;
      if (lc < 0 && run === 1'b1) lc = n;
      if (lm < 0 && cfm_en === 1'b1) lm = n;
    end
    check_range(lm - lr, CFM + 1, CFM + 1);
    e = (lr >= lg) ? lr + 1 : lg;
    check_range(lc, e, e);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    rst     = 1'b1;
    awaddr  = 4'h0;
    araddr  = 4'h0;
    wstrb   = 4'hF;
    wdata   = 32'h0;
    awvalid = 1'b0;
    wvalid  = 1'b0;
    bready  = 1'b0;
    arvalid = 1'b0;
    rready  = 1'b0;
    src     = 5'h00;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    for (int i = 0; i < 2000 && run !== 1'b1; i++) @(negedge sys_clk);
    axi_rd(RDCS_CFG_OFF, d, r);
    check_data(d, {24'h0, CFG_RESET});
    wstrb <= 4'h0;
    axi_wr(RDCS_CFG_OFF, 32'h00, r);
    wstrb <= 4'hF;
    check_data({30'h0, r}, {30'h0, RESP_OKAY});
    axi_rd(RDCS_CFG_OFF, d, r);
    check_data(d, {24'h0, CFG_RESET});
    axi_rd(RDCS_CAUSE_OFF, d, r);
    check_data(d, 32'h01);
    axi_wr(RDCS_CAUSE_OFF, 32'h1F, r);
    axi_rd(RDCS_CAUSE_OFF, d, r);
    check_data(d, 32'h0);
    axi_wr(RDCS_STAT_OFF, 32'hFF, r);
    check_data({30'h0, r}, {30'h0, RESP_SLVERR});
    axi_rd(4'h1, d, r);
    check_data({d[29:0], r}, {30'h0, RESP_SLVERR});
    // Delay per reset type, power-up timer on then off
    for (int p = 1; p >= 0; p--) begin
      axi_wr(RDCS_CFG_OFF, 32'h20 | (p << 1), r);
      run_seq(4);
      l0 = lr;
      run_seq(3);
      check_range(lr - l0, 0, 0);
      run_seq(2);
      check_range(lr - l0, 0, 0);
      run_seq(0);
      check_range(lr - l0, PORC + p * POWER_UP_TIMER, PORC + p * POWER_UP_TIMER);
      run_seq(1);
      check_range(lr - l0, p * POWER_UP_TIMER, p * POWER_UP_TIMER);
      axi_rd(RDCS_CAUSE_OFF, d, r);
      check_data(d, 32'h1F);
    end
    // Every source code with switching off
    for (int c = 0; c < 8; c++) begin
      axi_wr(RDCS_CFG_OFF, 32'h02 | (c << 4), r);
      run_seq(4);
      check_data({29'h0, act}, 32'(c));
      check_range(lg, dly[c] - 1, dly[c] + 4);
    end
    axi_wr(RDCS_CFG_OFF, 32'h42, r);
    run_seq(0);
    check_range(lg, OSCILLATOR_STARTUP_TIMER - 1, OSCILLATOR_STARTUP_TIMER + 4);
    axi_wr(RDCS_CFG_OFF, 32'h46, r);
    run_seq(4);
    check_range(lg, FRCD - 1, FRCD + 4);
    // Source choice per reset type
    axi_wr(RDCS_CFG_OFF, 32'h22, r);
    axi_wr(RDCS_CTRL_OFF, 32'h7, r);
    run_seq(4);
    check_data({29'h0, act}, 32'h2);
    axi_wr(RDCS_CFG_OFF, 32'h23, r);
    axi_wr(RDCS_CTRL_OFF, 32'h7, r);
    run_seq(4);
    check_data({29'h0, act}, 32'h7);
    run_seq(3);
    check_data({29'h0, act}, 32'h7);
    run_seq(1);
    check_data({29'h0, act}, 32'h2);
    axi_rd(RDCS_STAT_OFF, d, r);
    check_data(d & 32'h7F, 32'h2F);
    complete_run();
  end
endmodule // test_reset_delay_clock_select
`default_nettype wire
